// ==== pkg/psrc_defs.svh ====
// Register offsets, field positions and reset values of the peripheral reset block
`ifndef PSRC_DEFS_SVH
`define PSRC_DEFS_SVH

`define PSRC_BASE_ADDR      32'h400F_E000
`define PSRC_OFF_GROUP1     12'h044
`define PSRC_OFF_GROUP2     12'h048
`define PSRC_RESET_VALUE    32'h0000_0000

// Implemented bits of each control word
`define PSRC_GROUP1_IMPL    32'h000F_5017
`define PSRC_GROUP2_IMPL    32'h0000_201F

// Field positions, first word
`define PSRC_BIT_TIMER_UNIT_ZERO_RESET     16
`define PSRC_BIT_TIMER_UNIT_ONE_RESET     17
`define PSRC_BIT_TIMER_UNIT_TWO_RESET     18
`define PSRC_BIT_TIMER_UNIT_THREE_RESET     19
`define PSRC_BIT_TWI0       12
`define PSRC_BIT_TWI1       14
`define PSRC_BIT_SSP0       4
`define PSRC_BIT_ASER0      0
`define PSRC_BIT_ASER1      1
`define PSRC_BIT_ASER2      2

// Field positions, second word
`define PSRC_BIT_DMA        13
`define PSRC_BIT_PORTA      0
`define PSRC_BIT_PORTB      1
`define PSRC_BIT_PORTC      2
`define PSRC_BIT_PORTD      3
`define PSRC_BIT_PORTE      4

// AHB encodings
`define PSRC_HTRANS_NONSEQ  2'b10
`define PSRC_HTRANS_SEQ     2'b11
`define PSRC_HRESP_OKAY     1'b0

`endif

// ==== pkg/psrc_pkg.sv ====
// Types shared by the peripheral reset block
package psrc_pkg;

  // Register selected by an access
  typedef enum logic [1:0] {
    PSRC_SEL_NONE,
    PSRC_SEL_GROUP1,
    PSRC_SEL_GROUP2
  } psrc_sel_t;

  // Latched address phase of one transfer
  typedef struct packed {
    logic      valid;
    logic      write;
    psrc_sel_t sel;
  } psrc_aphase_t;

  // Reset outputs of the first group
  typedef struct packed {
    logic timer_unit_three_reset;
    logic timer_unit_two_reset;
    logic timer_unit_one_reset;
    logic timer_unit_zero_reset;
    logic two_wire_unit_one_reset;
    logic two_wire_unit_zero_reset;
    logic sync_serial_port_zero_reset;
    logic async_serial_two_reset;
    logic async_serial_one_reset;
    logic async_serial_zero_reset;
  } psrc_group1_rst_t;

  // Reset outputs of the second group
  typedef struct packed {
    logic dma_unit_reset;
    logic io_port_e_reset;
    logic io_port_d_reset;
    logic io_port_c_reset;
    logic io_port_b_reset;
    logic io_port_a_reset;
  } psrc_group2_rst_t;

endpackage

// ==== core/psrc_addr_dec.sv ====
// Address decoder of the peripheral reset block
`timescale 1ns/1ps
`include "psrc_defs.svh"

module psrc_addr_dec
  import psrc_pkg::*;
(
  input  wire logic [31:0] haddr,
  input  wire logic        hsel,
  input  wire logic [1:0]  htrans,
  input  wire logic [2:0]  hsize,
  output psrc_sel_t        sel,
  output logic             active
);

  // Word transfer inside the register window
  always_comb begin
    active = hsel && (htrans == `PSRC_HTRANS_NONSEQ || htrans == `PSRC_HTRANS_SEQ);
    sel    = PSRC_SEL_NONE;
    if (active && hsize == 3'd2 && haddr[1:0] == 2'b00) begin
      if (haddr[11:0] == `PSRC_OFF_GROUP1) begin
        sel = PSRC_SEL_GROUP1;
      end else if (haddr[11:0] == `PSRC_OFF_GROUP2) begin
        sel = PSRC_SEL_GROUP2;
      end
    end
  end

endmodule

// ==== core/psrc_ctl_word.sv ====
// One masked reset control word
`timescale 1ns/1ps
`include "psrc_defs.svh"

module psrc_ctl_word #(
  parameter logic [31:0] IMPL = 32'h0000_0000
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  input  wire logic [31:0] cap_mask,
  output logic      [31:0] value
);

  logic [31:0] wmask;

  // Only present and implemented bits take a write
  assign wmask = IMPL & cap_mask;

  // Word storage, cleared on reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value <= `PSRC_RESET_VALUE;
    end else if (wr_en) begin
      value <= (value & ~wmask) | (wr_data & wmask);
    end
  end

  // Bits outside the mask in force at the write never change
  chk_masked_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_en |=> ((value & ~$past(wmask)) == ($past(value) & ~$past(wmask))))
    else $error("masked bits changed on write");

  // Reserved positions always read zero
  chk_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (value & ~IMPL) == 32'h0000_0000)
    else $error("reserved bit set");

endmodule

// ==== core/psrc_top.sv ====
// AHB-Lite slave holding the two peripheral reset control words
// Summary of operation
// - First word writes gated by second capability mask
// - Second word writes gated by fourth capability mask
// - Words at offsets 0x044 and 0x048
// - Both words 32-bit read/write, reset zero
// - Bits 19..16 reset timers 3..0
// - Bit 14, 12 reset two-wire units 1, 0
// - Bit 4 resets sync serial port 0
// - Bits 2..0 reset async serial 2..0
// - Second word bit 13 resets DMA unit
// - Second word bits 4..0 reset ports E..A
// - Reserved bits read-only, read as zero
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "psrc_defs.svh"

module psrc_top
  import psrc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] capability_mask_second,
  input  wire logic [31:0] capability_mask_fourth,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output psrc_group1_rst_t group1_rst,
  output psrc_group2_rst_t group2_rst
);

  psrc_sel_t    dec_sel;
  logic         dec_active;
  psrc_aphase_t aphase;
  logic [31:0]  group1;
  logic [31:0]  group2;
  logic         wr_group1;
  logic         wr_group2;
  logic [31:0]  next_hrdata;

  // Address phase decode
  psrc_addr_dec u_dec (
    .haddr  (haddr),
    .hsel   (hsel),
    .htrans (htrans),
    .hsize  (hsize),
    .sel    (dec_sel),
    .active (dec_active)
  );

  // Latch the address phase when the bus moves on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aphase <= '0;
    end else if (hready) begin
      aphase.valid <= dec_active;
      aphase.write <= hwrite;
      aphase.sel   <= dec_sel;
    end
  end

  // Data-phase write strobes
  assign wr_group1 = aphase.valid && aphase.write && aphase.sel == PSRC_SEL_GROUP1;
  assign wr_group2 = aphase.valid && aphase.write && aphase.sel == PSRC_SEL_GROUP2;

  // First reset control word
  psrc_ctl_word #(
    .IMPL (`PSRC_GROUP1_IMPL)
  ) u_group1 (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .wr_en    (wr_group1),
    .wr_data  (hwdata),
    .cap_mask (capability_mask_second),
    .value    (group1)
  );

  // Second reset control word
  psrc_ctl_word #(
    .IMPL (`PSRC_GROUP2_IMPL)
  ) u_group2 (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .wr_en    (wr_group2),
    .wr_data  (hwdata),
    .cap_mask (capability_mask_fourth),
    .value    (group2)
  );

  // Read data prepared in the address phase, unmapped reads zero
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (hready && dec_active && !hwrite) begin
      unique case (dec_sel)
        PSRC_SEL_GROUP1: next_hrdata = group1;
        PSRC_SEL_GROUP2: next_hrdata = group2;
        PSRC_SEL_NONE:   next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready) begin
      hrdata <= next_hrdata;
    end
  end

  // Zero wait state, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= `PSRC_HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= `PSRC_HRESP_OKAY;
    end
  end

  // Peripheral resets follow the stored words one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      group1_rst <= '0;
      group2_rst <= '0;
    end else begin
      group1_rst.timer_unit_three_reset      <= group1[`PSRC_BIT_TIMER_UNIT_THREE_RESET];
      group1_rst.timer_unit_two_reset        <= group1[`PSRC_BIT_TIMER_UNIT_TWO_RESET];
      group1_rst.timer_unit_one_reset        <= group1[`PSRC_BIT_TIMER_UNIT_ONE_RESET];
      group1_rst.timer_unit_zero_reset       <= group1[`PSRC_BIT_TIMER_UNIT_ZERO_RESET];
      group1_rst.two_wire_unit_one_reset     <= group1[`PSRC_BIT_TWI1];
      group1_rst.two_wire_unit_zero_reset    <= group1[`PSRC_BIT_TWI0];
      group1_rst.sync_serial_port_zero_reset <= group1[`PSRC_BIT_SSP0];
      group1_rst.async_serial_two_reset      <= group1[`PSRC_BIT_ASER2];
      group1_rst.async_serial_one_reset      <= group1[`PSRC_BIT_ASER1];
      group1_rst.async_serial_zero_reset     <= group1[`PSRC_BIT_ASER0];
      group2_rst.dma_unit_reset              <= group2[`PSRC_BIT_DMA];
      group2_rst.io_port_e_reset             <= group2[`PSRC_BIT_PORTE];
      group2_rst.io_port_d_reset             <= group2[`PSRC_BIT_PORTD];
      group2_rst.io_port_c_reset             <= group2[`PSRC_BIT_PORTC];
      group2_rst.io_port_b_reset             <= group2[`PSRC_BIT_PORTB];
      group2_rst.io_port_a_reset             <= group2[`PSRC_BIT_PORTA];
    end
  end

  // Permitted timer zero write, seen in the data phase
  sequence seq_timer_unit_zero_reset_set_write;
    wr_group1 && hwdata[`PSRC_BIT_TIMER_UNIT_ZERO_RESET] && capability_mask_second[`PSRC_BIT_TIMER_UNIT_ZERO_RESET];
  endsequence

  // Timer zero line high one edge after the word lands
  sequence seq_timer_unit_zero_reset_line_high;
    ##1 group1_rst.timer_unit_zero_reset;
  endsequence

  // A permitted write of one reaches the timer reset two edges later
  chk_timer_reset_set: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_timer_unit_zero_reset_set_write |=> seq_timer_unit_zero_reset_line_high)
    else $error("timer zero reset not asserted");

  // Present two-wire bit takes the written value
  chk_group1_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_group1 && capability_mask_second[`PSRC_BIT_TWI1])
      |=> group1[`PSRC_BIT_TWI1] == $past(hwdata[`PSRC_BIT_TWI1]))
    else $error("two-wire one bit not written");

  // Absent timer three keeps its bit on a write
  chk_group1_mask: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_group1 && !capability_mask_second[`PSRC_BIT_TIMER_UNIT_THREE_RESET])
      |=> $stable(group1[`PSRC_BIT_TIMER_UNIT_THREE_RESET]))
    else $error("timer three bit changed while absent");

  // Absent DMA unit keeps its bit on a write
  chk_group2_mask: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_group2 && !capability_mask_fourth[`PSRC_BIT_DMA])
      |=> $stable(group2[`PSRC_BIT_DMA]))
    else $error("dma bit changed while absent");

  // Present DMA bit takes the written value
  chk_group2_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_group2 && capability_mask_fourth[`PSRC_BIT_DMA])
      |=> group2[`PSRC_BIT_DMA] == $past(hwdata[`PSRC_BIT_DMA]))
    else $error("dma bit not written");

  // A cleared bit releases its peripheral
  chk_port_release: assert property (@(posedge hclk) disable iff (!hresetn)
    !group2[`PSRC_BIT_PORTA] |=> !group2_rst.io_port_a_reset)
    else $error("port a reset held after clear");

  // Each reset line follows its stored bit one edge later
  chk_port_map: assert property (@(posedge hclk) disable iff (!hresetn)
    group2_rst.io_port_e_reset == $past(group2[`PSRC_BIT_PORTE]))
    else $error("port e reset mismatched");

  chk_ssp_map: assert property (@(posedge hclk) disable iff (!hresetn)
    group1_rst.sync_serial_port_zero_reset == $past(group1[`PSRC_BIT_SSP0]))
    else $error("sync serial reset mismatched");

  chk_timer_map: assert property (@(posedge hclk) disable iff (!hresetn)
    {group1_rst.timer_unit_three_reset, group1_rst.timer_unit_two_reset,
     group1_rst.timer_unit_one_reset, group1_rst.timer_unit_zero_reset}
      == $past(group1[`PSRC_BIT_TIMER_UNIT_THREE_RESET:`PSRC_BIT_TIMER_UNIT_ZERO_RESET]))
    else $error("timer reset lines mismatched");

  chk_twowire_map: assert property (@(posedge hclk) disable iff (!hresetn)
    {group1_rst.two_wire_unit_one_reset, group1_rst.two_wire_unit_zero_reset}
      == $past({group1[`PSRC_BIT_TWI1], group1[`PSRC_BIT_TWI0]}))
    else $error("two-wire reset lines mismatched");

  chk_async_map: assert property (@(posedge hclk) disable iff (!hresetn)
    {group1_rst.async_serial_two_reset, group1_rst.async_serial_one_reset,
     group1_rst.async_serial_zero_reset}
      == $past(group1[`PSRC_BIT_ASER2:`PSRC_BIT_ASER0]))
    else $error("async serial reset lines mismatched");

  chk_dma_map: assert property (@(posedge hclk) disable iff (!hresetn)
    group2_rst.dma_unit_reset == $past(group2[`PSRC_BIT_DMA]))
    else $error("dma reset line mismatched");

  chk_ports_map: assert property (@(posedge hclk) disable iff (!hresetn)
    {group2_rst.io_port_e_reset, group2_rst.io_port_d_reset, group2_rst.io_port_c_reset,
     group2_rst.io_port_b_reset, group2_rst.io_port_a_reset}
      == $past(group2[`PSRC_BIT_PORTE:`PSRC_BIT_PORTA]))
    else $error("port reset lines mismatched");

  // Unmapped reads return zero
  chk_read_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (hready && dec_active && !hwrite && dec_sel == PSRC_SEL_NONE) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");

  // Slave never stalls and always answers OKAY
  chk_ready_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && hresp == `PSRC_HRESP_OKAY)
    else $error("slave stalled or errored");

endmodule

// ==== verif/psrc_tb.sv ====
// Self-checking bench for the peripheral reset control block
`timescale 1ns/1ps

module testbench
  import psrc_pkg::*;
;
  localparam logic [31:0] G1 = 32'h400F_E044;
  localparam logic [31:0] G2 = 32'h400F_E048;

  logic             hclk;
  logic             hresetn;
  logic             hsel;
  logic [31:0]      haddr;
  logic [1:0]       htrans;
  logic             hwrite;
  logic [2:0]       hsize;
  logic [31:0]      hwdata;
  logic [31:0]      capability_mask_second;
  logic [31:0]      capability_mask_fourth;
  logic [31:0]      hrdata;
  logic             hreadyout;
  logic             hresp;
  psrc_group1_rst_t group1_rst;
  psrc_group2_rst_t group2_rst;
  logic [31:0]      rd;
  int               errors;
  int               compares;

  psrc_top dut_u (
    .hclk                   (hclk),
    .hresetn                (hresetn),
    .hsel                   (hsel),
    .haddr                  (haddr),
    .htrans                 (htrans),
    .hwrite                 (hwrite),
    .hsize                  (hsize),
    .hwdata                 (hwdata),
    .hready                 (hreadyout),
    .capability_mask_second (capability_mask_second),
    .capability_mask_fourth (capability_mask_fourth),
    .hrdata                 (hrdata),
    .hreadyout              (hreadyout),
    .hresp                  (hresp),
    .group1_rst             (group1_rst),
    .group2_rst             (group2_rst)
  );

  // Clock at 25 MHz
  always #20 hclk = ~hclk;

  // Prints the counts and the verdict, then stops
  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compares a register word
  task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Compares both groups of reset lines at once
  task automatic chk_lines(input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Waits for a rising edge at which ready is sampled high, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 64) begin
      @(posedge hclk);
      n++;
    end
    if (hreadyout !== 1'b1) begin
      errors++;
      summarize();
    end
  endtask

  // One single transfer: address phase, then data phase
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  // Write, check the reset lines one cycle after the word lands, read back
  task automatic wr_lines(input logic [31:0] a, input logic [31:0] d,
                          input logic [31:0] ew, input logic [15:0] el);
    xfer(a, 1'b1, d);
    @(posedge hclk);
    @(negedge hclk);
    chk_lines(el, {group1_rst, group2_rst});
    @(posedge hclk);
    xfer(a, 1'b0, 32'h0000_0000);
    chk_word(ew, rd);
  endtask

  task automatic t_reset();
    xfer(G1, 1'b0, 32'h0000_0000);
    chk_word(32'h0000_0000, rd);
    xfer(G2, 1'b0, 32'h0000_0000);
    chk_word(32'h0000_0000, rd);
    $display("test reset values done");
  endtask

  task automatic t_fields();
    int b1 [10] = '{19, 18, 17, 16, 14, 12, 4, 2, 1, 0};
    int b2 [6] = '{13, 4, 3, 2, 1, 0};
    for (int i = 0; i < 10; i++) begin
      wr_lines(G1, 32'h0000_0001 << b1[i], 32'h0000_0001 << b1[i], 16'h8000 >> i);
    end
    wr_lines(G1, 32'hFFFF_FFFF, 32'h000F_5017, 16'hFFC0);
    wr_lines(G1, 32'h0000_0000, 32'h0000_0000, 16'h0000);
    for (int j = 0; j < 6; j++) begin
      wr_lines(G2, 32'h0000_0001 << b2[j], 32'h0000_0001 << b2[j], 16'h0020 >> j);
    end
    wr_lines(G2, 32'hFFFF_FFFF, 32'h0000_201F, 16'h003F);
    wr_lines(G2, 32'h0000_0000, 32'h0000_0000, 16'h0000);
    $display("test field mapping done");
  endtask

  // Absent peripherals keep their old bit when the mask is cleared
  task automatic t_masks();
    wr_lines(G1, 32'hFFFF_FFFF, 32'h000F_5017, 16'hFFC0);
    capability_mask_second <= 32'h0001_0001;
    wr_lines(G1, 32'h0000_0000, 32'h000E_5016, 16'hEF80);
    capability_mask_fourth <= 32'h0000_0004;
    wr_lines(G2, 32'hFFFF_FFFF, 32'h0000_0004, 16'hEF84);
    capability_mask_second <= 32'hFFFF_FFFF;
    capability_mask_fourth <= 32'hFFFF_FFFF;
    $display("test capability masks done");
  endtask

  // Unmapped offset and a byte-sized access must not touch the first word
  task automatic t_refuse();
    xfer(32'h400F_E04C, 1'b1, 32'hFFFF_FFFF);
    chk_word(32'h0000_0000, {31'h0000_0000, hresp});
    xfer(32'h400F_E04C, 1'b0, 32'h0000_0000);
    chk_word(32'h0000_0000, rd);
    hsize <= 3'b000;
    xfer(G1, 1'b1, 32'h0000_0000);
    hsize <= 3'b010;
    xfer(G1, 1'b0, 32'h0000_0000);
    chk_word(32'h000E_5016, rd);
    $display("test refused accesses done");
  endtask

  // Reset in mid-run clears both words and every reset line
  task automatic t_midreset();
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk_lines(16'h0000, {group1_rst, group2_rst});
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(G1, 1'b0, 32'h0000_0000);
    chk_word(32'h0000_0000, rd);
    xfer(G2, 1'b0, 32'h0000_0000);
    chk_word(32'h0000_0000, rd);
    $display("test mid-run reset done");
  endtask

  // Reset for four cycles, then the scenarios
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    capability_mask_second = 32'hFFFF_FFFF;
    capability_mask_fourth = 32'hFFFF_FFFF;
    errors = 0;
    compares = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_fields();
    t_masks();
    t_refuse();
    t_midreset();
    summarize();
  end
endmodule
